//--- bench/bert_rx_checker_asserts.sv
// Port-level checks of the pattern receiver.
`timescale 1ns/1ps
module bert_rx_checker
(
    input wire        clk,
    input wire        reset_n,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        receive_bit_gate,
    input wire        normal_rx_data,
    input wire        normal_path_data,
    input wire        normal_path_halted,
    input wire        pattern_lock_lost,
    input wire        counter_latch_done,
    input wire        count_nonzero
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Bus answers one cycle after a request and reads hold.
    a_bus_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("bus answer late");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved");
    // Normal path is cut while testing and follows input otherwise.
    a_halt_quiet: assert property (normal_path_halted && $past(normal_path_halted) |-> !normal_path_data)
        else $error("normal path not halted");
    a_path_back: assert property ((!normal_path_halted && $stable(normal_rx_data)) [*5] |->
        normal_path_data == normal_rx_data)
        else $error("normal path not restored");
    // Lock is only gained on a payload bit.
    a_lock_gate: assert property ($fell(pattern_lock_lost) |-> $past(receive_bit_gate, 4))
        else $error("lock on skipped bit");
    // Update drops done briefly with zero status low.
    a_done_back: assert property ($fell(counter_latch_done) |-> ##[1:3] counter_latch_done)
        else $error("done not back");
    a_zero_update: assert property (!counter_latch_done |-> !count_nonzero)
        else $error("nonzero during update");
    a_reset_state: assert property (disable iff (1'b0) !reset_n |=> pattern_lock_lost && !normal_path_halted)
        else $error("bad reset state");
    // Main scenarios.
    c_lock: cover property ($fell(pattern_lock_lost));
    c_resync: cover property ($rose(pattern_lock_lost));
    c_update: cover property ($rose(counter_latch_done));
endmodule
bind bert_pattern_receiver bert_rx_checker i_chk (.clk(clk), .reset_n(reset_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .receive_bit_gate(receive_bit_gate), .normal_rx_data(normal_rx_data), .normal_path_data(normal_path_data),
    .normal_path_halted(normal_path_halted), .pattern_lock_lost(pattern_lock_lost),
    .counter_latch_done(counter_latch_done), .count_nonzero(count_nonzero));

//--- bench/far_pattern_source.sv
// Far-end pattern source driving the serial receive line.
`timescale 1ns/1ps
module far_pattern_source
(
    output reg line_clk,
    output reg line_data,
    output reg receive_bit_gate
);
    // ****
    // Source
    // ****
    reg [31:0] gen_q;
    reg        fb;
    integer    len_n;
    integer    tap_y;
    integer    rep;
    integer    sent;
    integer    slot;
    // Line is idle with its clock stopped.
    initial
    begin
        line_clk = 1'b0;
        line_data = 1'b0;
        receive_bit_gate = 1'b0;
    end
    // Loads a pattern and restarts the payload count.
    task setup(input integer n, input integer y, input integer r, input [31:0] seed);
    begin
        len_n = n;
        tap_y = y;
        rep = r;
        gen_q = seed;
        sent = 0;
    end
    endtask
    // Sends count payload bits; err_num bits from index err_at go out inverted.
    task send(input integer count, input integer err_at, input integer err_num, input integer gap);
    begin
        slot = 0;
        #37;
        while (count > 0)
        begin
            slot = slot + 1;
            receive_bit_gate = !(gap != 0 && slot % 3 == 0);
            // shift up, feedback into bit 1 and out.
            fb = rep ? gen_q[len_n-1] : gen_q[len_n-1] ^ gen_q[tap_y-1];
            fb = fb | (rep == 0 && gen_q[30:0] == 31'h0);
            // skipped slots carry a garbage bit and leave the pattern alone.
            if (receive_bit_gate)
            begin
                gen_q = {gen_q[30:0], fb};
                sent = sent + 1;
                count = count - 1;
                line_data = fb ^ (sent >= err_at && sent < err_at + err_num);
            end
            else
                line_data = ~line_data;
            #400 line_clk = 1'b1;
            #400 line_clk = 1'b0;
        end
        line_data = ~line_data;
        receive_bit_gate = 1'b0;
    end
    endtask
endmodule

//--- bench/tb_bert_pattern_receiver.sv
// Self-checking bench of the pattern receiver.
`timescale 1ns/1ps
`include "bert_rx_consts.vh"
module tb_bert_pattern_receiver;
    reg         clk;
    reg         reset_n;
    reg  [3:0]  avs_address;
    reg         avs_read;
    reg         avs_write;
    reg  [31:0] avs_writedata;
    reg         normal_rx_data = 1'b0;
    reg  [31:0] rd;
    reg  [31:0] ctrl;
    reg  [31:0] rnd = 32'h0000_90b1;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, line_clk, line_data, receive_bit_gate, normal_path_data;
    wire        normal_path_halted, pattern_lock_lost, counter_latch_done, count_nonzero;
    integer     failures, check_count, i, t;
    // ****
    // Harness
    // ****
    bert_pattern_receiver i_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_clk(line_clk),
        .line_data(line_data), .receive_bit_gate(receive_bit_gate), .normal_rx_data(normal_rx_data),
        .normal_path_data(normal_path_data), .normal_path_halted(normal_path_halted),
        .pattern_lock_lost(pattern_lock_lost), .counter_latch_done(counter_latch_done),
        .count_nonzero(count_nonzero));
    far_pattern_source i_far (.line_clk(line_clk), .line_data(line_data), .receive_bit_gate(receive_bit_gate));
    // Clock and watchdog.
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #2000000;
        failures = failures + 1;
        tally_and_finish;
    end
    function [31:0] xs(input [31:0] v);
        reg [31:0] w;
    begin
        w = v ^ (v << 13);
        w = w ^ (w >> 17);
        xs = w ^ (w << 5);
    end
    endfunction
    // Random normal traffic.
    always @(posedge clk)
    begin
        rnd <= xs(rnd);
        if (rnd[2:0] == 3'h0)
            normal_rx_data <= rnd[8];
    end
    task check(input [31:0] seen, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    end
    endtask
    // One Avalon transfer; read data lands in rd; only the watchdog ends a wait that never completes.
    task bus(input wr, input [3:0] a, input [31:0] wd);
    begin
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    end
    endtask
    task wait_lost(input v);
    begin
        t = 0;
        while (pattern_lock_lost !== v && t < 40)
        begin
            @(posedge clk);
            t = t + 1;
        end
        check(pattern_lock_lost, v);
    end
    endtask
    // Latches the counters and compares them with the expected counts.
    task latch(input integer bits, input integer errs);
    begin
        bus(1, `REG_CTRL, ctrl | 32'h40);
        bus(0, `REG_BIT_COUNT, 0);
        check(rd, bits);
        bus(0, `REG_ERR_COUNT, 0);
        check(rd, errs);
        check(count_nonzero, errs != 0);
        check(counter_latch_done, 1'b1);
        bus(1, `REG_CTRL, ctrl);
    end
    endtask
    task tally_and_finish;
    begin
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    // ****
    // Scenarios
    // ****
    initial
    begin
        reset_n = 1'b0;
        {avs_address, avs_read, avs_write, avs_writedata} = 38'h0;
        failures = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        for (i = 0; i < 7; i = i + 1)
        begin
            bus(0, i == 6 ? 4'hf : i[3:0], 0);
            check(rd, i == 1 ? `POLY_RESET : i == 3 ? 32'h2 : 0);
        end
        ctrl = 32'h1;
        bus(1, `REG_CTRL, ctrl);
        bus(0, `REG_STATUS, 0);
        check(rd[3:0], 4'h3);
        check(normal_path_halted, 1'b1);
        check(normal_path_data, 1'b0);
        for (i = 0; i < 3; i = i + 1)
        begin
            bus(1, `REG_POLY, i == 0 ? 32'h0509 : i == 1 ? 32'h0e0f : 32'h1217);
            wait_lost(1'b1);
            i_far.setup(i == 0 ? 9 : i == 1 ? 15 : 23, i == 0 ? 5 : i == 1 ? 14 : 18, 0, 32'hffff_ffff);
            i_far.send(63, 999, 0, 0);
            repeat (10) @(posedge clk);
            check(pattern_lock_lost, 1'b1);
            i_far.send(1, 999, 0, 0);
            wait_lost(1'b0);
        end
        i_far.send(136, 100 + rnd[2:0], 3, 1);
        latch(136, 3);
        latch(0, 0);
        i_far.send(30, 202, 6, 0);
        check(pattern_lock_lost, 1'b1);
        i_far.send(45, 999, 0, 0);
        wait_lost(1'b0);
        ctrl = 32'h11;
        bus(1, `REG_CTRL, ctrl | 32'h20);
        bus(0, `REG_CTRL, 0);
        check(rd, ctrl);
        wait_lost(1'b1);
        i_far.setup(23, 18, 0, 32'hffff_ffff);
        i_far.send(64, 999, 0, 0);
        wait_lost(1'b0);
        i_far.send(40, 70, 6, 0);
        repeat (10) @(posedge clk);
        check(pattern_lock_lost, 1'b0);
        latch(40, 6);
        ctrl = 32'h3;
        bus(1, `REG_CTRL, ctrl);
        bus(1, `REG_POLY, 32'h0008);
        bus(1, `REG_PATTERN, 32'h00a5);
        i_far.setup(8, 1, 1, 32'h00a5);
        i_far.send(80, 999, 0, 0);
        wait_lost(1'b0);
        i_far.send(20, 83, 6, 0);
        check(pattern_lock_lost, 1'b1);
        ctrl = 32'h0;
        bus(1, `REG_CTRL, ctrl);
        repeat (3) @(posedge clk);
        check(normal_path_halted, 1'b0);
        check(pattern_lock_lost, 1'b1);
        repeat (60) @(posedge clk);
        tally_and_finish;
    end
endmodule

//--- rtl/bert_pattern_receiver.v
// Receive pattern checker for the serial TDM port with Avalon-MM register access.
// Function
// - Generator is 32-bit shift register, bit 1 toward bit 32, feedback into bit 1.
// - PRBS feedback is XOR of tap n and tap y.
// - Repetitive feedback is tap n; n and y each programmable 1 to 32.
// - Comparison bit equals the feedback bit.
// - QRSS taps 17 and 20; output forced one after 14 zeros; switchable.
// - PRBS/QRSS feedback forced one when bits 1 to 31 are zero.
// - Pattern type selects PRBS or repetitive lock procedure.
// - PRBS lock loads 32 bits, then all next 32 must match.
// - PRBS resync when errors in 64-bit window reach six.
// - Repetitive lock searches each position, then 32 bits must match.
// - Repetitive resync uses the same 64-bit window threshold.
// - Software can disable automatic resynchronization.
// - PRBS/QRSS lengths 2^9-1, 2^15-1 and 2^23-1 offered.
// - Repetitive length 1 to 32 and value 0 to 2^n-1.
// - 24-bit error counter and 32-bit bit counter readable.
// - Only bits with the gate input high are test data.
// - While enabled, normal traffic halts and port connects to tester.
// - When disabled, normal connection is restored.
// - Tester keeps running in X.86 mode with gate configured as output.
// - Receive path extracts payload and checks it against pattern.
// - Lock-lost reported whenever the sync machine is not locked.
// - Each bit counts; mismatches count errors; no counting while unlocked.
// - Counters saturate; rising edge of latch request starts update.
// - Update drops done, copies, clears, pulses zero status low, raises done.
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "bert_rx_consts.vh"
module bert_pattern_receiver
(
    input  wire        clk,
    input  wire        reset_n,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        line_clk,
    input  wire        line_data,
    input  wire        receive_bit_gate,
    input  wire        normal_rx_data,
    output reg         normal_path_data,
    output reg         normal_path_halted,
    output reg         pattern_lock_lost,
    output reg         counter_latch_done,
    output reg         count_nonzero
);

    // ****************************************************************
    // Register file and bus slave
    // ****************************************************************
    reg  [31:0] ctrl_q;
    reg  [31:0] poly_q;
    reg  [31:0] pattern_q;
    reg  [31:0] bit_latch_q;
    reg  [23:0] err_latch_q;
    reg         access_q;
    wire        new_pattern;

    // A load strobe or a write to the pattern setup starts a fresh lock attempt on the completing edge.
    assign new_pattern = avs_write && access_q &&
        (avs_address == `REG_POLY || avs_address == `REG_PATTERN ||
         (avs_address == `REG_CTRL && avs_writedata[`CTRL_LOAD]));

    // Every access is answered one cycle after it is presented.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            access_q        <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            access_q        <= (avs_read || avs_write) && !access_q;
            avs_waitrequest <= !((avs_read || avs_write) && !access_q);
        end
    end

    // Writes land on the completing edge, while waitrequest is low; load bit is self clearing.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            ctrl_q    <= `CTRL_RESET;
            poly_q    <= `POLY_RESET;
            pattern_q <= `PATTERN_RESET;
        end
        else if (avs_write && access_q)
        begin
            case (avs_address)
                `REG_CTRL:    ctrl_q    <= avs_writedata & 32'hffff_ffdf;
                `REG_POLY:    poly_q    <= avs_writedata;
                `REG_PATTERN: pattern_q <= avs_writedata;
                default:      ctrl_q    <= ctrl_q;
            endcase
        end
    end

    // Read data; unmapped words read as zero.
    always @(posedge clk)
    begin
        if (!reset_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && !access_q)
        begin
            case (avs_address)
                `REG_CTRL:      avs_readdata <= ctrl_q;
                `REG_POLY:      avs_readdata <= poly_q;
                `REG_PATTERN:   avs_readdata <= pattern_q;
                `REG_STATUS:    avs_readdata <= {28'h0000000, count_nonzero, counter_latch_done,
                                                 pattern_lock_lost, ctrl_q[`CTRL_ENABLE]};
                `REG_BIT_COUNT: avs_readdata <= bit_latch_q;
                `REG_ERR_COUNT: avs_readdata <= {8'h00, err_latch_q};
                default:        avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Line input synchronisers and bit strobe
    // ****************************************************************
    reg  [1:0] clk_sync_q;
    reg  [1:0] data_sync_q;
    reg  [1:0] gate_sync_q;
    reg  [1:0] norm_sync_q;
    reg        clk_prev_q;
    wire       line_rise;
    wire       bit_valid;

    // Two flip-flops on every input from the line clock domain.
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            clk_sync_q  <= 2'b00;
            data_sync_q <= 2'b00;
            gate_sync_q <= 2'b00;
            norm_sync_q <= 2'b00;
            clk_prev_q  <= 1'b0;
        end
        else
        begin
            clk_sync_q  <= {clk_sync_q[0], line_clk};
            data_sync_q <= {data_sync_q[0], line_data};
            gate_sync_q <= {gate_sync_q[0], receive_bit_gate};
            norm_sync_q <= {norm_sync_q[0], normal_rx_data};
            clk_prev_q  <= clk_sync_q[1];
        end
    end

    assign line_rise = clk_sync_q[1] && !clk_prev_q;
    assign bit_valid = line_rise && gate_sync_q[1] && ctrl_q[`CTRL_ENABLE];

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            normal_path_halted <= 1'b0;
            normal_path_data   <= 1'b0;
        end
        else
        begin
            normal_path_halted <= ctrl_q[`CTRL_ENABLE];
            normal_path_data   <= ctrl_q[`CTRL_ENABLE] ? 1'b0 : norm_sync_q[1];
        end
    end

    // ****************************************************************
    // Receive pattern generator
    // ****************************************************************
    reg  [31:0] gen_q;
    wire [4:0]  tap_n;
    wire [4:0]  tap_y;
    wire        is_repeat;
    wire        qrss;
    wire        fb_raw;
    wire        feedback;
    wire        expected;
    wire [31:0] rep_mask;

    // n and y fields, value 0 means 32
    assign tap_n     = poly_q[4:0] - 5'h01;
    assign tap_y     = poly_q[12:8] - 5'h01;
    assign is_repeat = ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_REPEAT;
    assign qrss      = ctrl_q[`CTRL_QRSS] && !is_repeat;
    assign fb_raw = is_repeat ? gen_q[tap_n] :
                    qrss ? (gen_q[`QRSS_TAP_A-1] ^ gen_q[`QRSS_TAP_B-1]) :
                    (gen_q[tap_n] ^ gen_q[tap_y]);
    assign feedback = (!is_repeat && gen_q[30:0] == 31'h0000_0000) ? 1'b1 : fb_raw;
    assign expected = (qrss && gen_q[`QRSS_ZERO_RUN-1:0] == 14'h0000) ? 1'b1 : feedback;
    assign rep_mask = (poly_q[4:0] == 5'h00) ? 32'hffff_ffff : ((32'h0000_0001 << poly_q[4:0]) - 32'h0000_0001);

    // ****************************************************************
    // Synchronisation state machine
    // ****************************************************************
    reg  [1:0] state_q;
    reg  [5:0] sync_cnt_q;
    reg  [6:0] win_cnt_q;
    reg  [6:0] win_err_q;
    reg  [31:0] hist_q;
    wire       mismatch;
    wire       in_sync;

    assign mismatch = data_sync_q[1] != expected;
    assign in_sync  = state_q == `ST_SYNC;

    always @(posedge clk)
    begin
        if (!reset_n || new_pattern || !ctrl_q[`CTRL_ENABLE])
        begin
            state_q    <= is_repeat ? `ST_SEARCH : `ST_LOAD;
            sync_cnt_q <= 6'h00;
            win_cnt_q  <= 7'h00;
            win_err_q  <= 7'h00;
            gen_q      <= 32'h0000_0000;
            hist_q     <= 32'h0000_0000;
        end
        else if (bit_valid)
        begin
            hist_q <= {hist_q[30:0], data_sync_q[1]};
            case (state_q)
                `ST_LOAD:
                begin
                    gen_q      <= {gen_q[30:0], data_sync_q[1]};
                    sync_cnt_q <= sync_cnt_q + 6'h01;
                    if (sync_cnt_q == `SYNC_BITS - 6'h01)
                    begin
                        state_q    <= `ST_VERIFY;
                        sync_cnt_q <= 6'h00;
                    end
                end
                `ST_SEARCH:
                begin
                    if ((({hist_q[30:0], data_sync_q[1]} ^ pattern_q) & rep_mask) == 32'h0000_0000)
                    begin
                        gen_q      <= {hist_q[30:0], data_sync_q[1]};
                        state_q    <= `ST_VERIFY;
                        sync_cnt_q <= 6'h00;
                    end
                end
                `ST_VERIFY:
                begin
                    gen_q      <= {gen_q[30:0], feedback};
                    sync_cnt_q <= sync_cnt_q + 6'h01;
                    if (mismatch)
                        state_q <= is_repeat ? `ST_SEARCH : `ST_LOAD;
                    else if (sync_cnt_q == `SYNC_BITS - 6'h01)
                    begin
                        state_q   <= `ST_SYNC;
                        win_cnt_q <= 7'h00;
                        win_err_q <= 7'h00;
                    end
                    if (mismatch || sync_cnt_q == `SYNC_BITS - 6'h01)
                        sync_cnt_q <= 6'h00;
                end
                `ST_SYNC:
                begin
                    gen_q <= {gen_q[30:0], feedback};
                    win_cnt_q <= (win_cnt_q == `WINDOW_BITS - 7'h01) ? 7'h00 : win_cnt_q + 7'h01;
                    if (win_cnt_q == `WINDOW_BITS - 7'h01)
                        win_err_q <= 7'h00;
                    else if (mismatch)
                        win_err_q <= win_err_q + 7'h01;
                    if (mismatch && win_err_q + 7'h01 >= `ERR_THRESHOLD && !ctrl_q[`CTRL_NO_RESYNC])
                    begin
                        state_q    <= is_repeat ? `ST_SEARCH : `ST_LOAD;
                        sync_cnt_q <= 6'h00;
                    end
                end
                default: state_q <= `ST_LOAD;
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (!reset_n)
            pattern_lock_lost <= 1'b1;
        else
            pattern_lock_lost <= !in_sync;
    end

    // ****************************************************************
    // Bit and error counters with latch update
    // ****************************************************************
    reg  [31:0] bit_cnt_q;
    reg  [23:0] err_cnt_q;
    reg         update_prev_q;
    reg  [1:0]  upd_phase_q;
    wire        update_rise;
    wire        count_bit;
    wire        count_err;
    wire [31:0] bit_inc;
    wire [23:0] err_inc;

    assign update_rise = ctrl_q[`CTRL_UPDATE] && !update_prev_q;
    assign count_bit   = bit_valid && in_sync;
    assign count_err   = count_bit && mismatch;
    assign bit_inc = (bit_cnt_q == 32'hffff_ffff) ? bit_cnt_q : bit_cnt_q + 32'h0000_0001;
    assign err_inc = (err_cnt_q == 24'hff_ffff) ? err_cnt_q : err_cnt_q + 24'h00_0001;

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            bit_cnt_q          <= 32'h0000_0000;
            err_cnt_q          <= 24'h00_0000;
            bit_latch_q        <= 32'h0000_0000;
            err_latch_q        <= 24'h00_0000;
            update_prev_q      <= 1'b0;
            upd_phase_q        <= 2'h0;
            counter_latch_done <= 1'b0;
            count_nonzero      <= 1'b0;
        end
        else
        begin
            update_prev_q <= ctrl_q[`CTRL_UPDATE];
            if (update_rise)
            begin
                bit_latch_q        <= count_bit ? bit_inc : bit_cnt_q;
                err_latch_q        <= count_err ? err_inc : err_cnt_q;
                bit_cnt_q          <= 32'h0000_0000;
                err_cnt_q          <= 24'h00_0000;
                counter_latch_done <= 1'b0;
                count_nonzero      <= 1'b0;
                upd_phase_q        <= 2'h1;
            end
            else
            begin
                if (count_bit)
                    bit_cnt_q <= bit_inc;
                if (count_err)
                    err_cnt_q <= err_inc;
                if (upd_phase_q == 2'h1)
                begin
                    count_nonzero      <= err_latch_q != 24'h00_0000;
                    counter_latch_done <= 1'b1;
                    upd_phase_q        <= 2'h0;
                end
            end
            // counters cleared
            // Only the live counts restart, so a pending update still completes its done status.
            if (new_pattern)
            begin
                bit_cnt_q <= 32'h0000_0000;
                err_cnt_q <= 24'h00_0000;
            end
        end
    end

endmodule

//--- rtl/bert_rx_consts.vh
// Constants for the pattern receiver: register offsets, field positions, reset values and counts.
`ifndef BERT_RX_CONSTS_VH
`define BERT_RX_CONSTS_VH
// Register word addresses (one per 32-bit register).
`define REG_CTRL         4'h0
`define REG_POLY         4'h1
`define REG_PATTERN      4'h2
`define REG_STATUS       4'h3
`define REG_BIT_COUNT    4'h4
`define REG_ERR_COUNT    4'h5
// Control register field positions.
`define CTRL_ENABLE      0
`define CTRL_MODE_LO     1
`define CTRL_MODE_HI     2
`define CTRL_QRSS        3
`define CTRL_NO_RESYNC   4
`define CTRL_LOAD        5
`define CTRL_UPDATE      6
// Pattern modes.
`define MODE_PRBS        2'h0
`define MODE_REPEAT      2'h1
// Sync state codes.
`define ST_LOAD          2'h0
`define ST_VERIFY        2'h1
`define ST_SYNC          2'h2
`define ST_SEARCH        2'h3
// Reset values.
`define CTRL_RESET       32'h0000_0000
`define POLY_RESET       32'h0000_0e12
`define PATTERN_RESET    32'h0000_0000
// Counts.
`define SYNC_BITS        6'h20
`define WINDOW_BITS      7'h40
`define ERR_THRESHOLD    7'h06
`define QRSS_TAP_A       17
`define QRSS_TAP_B       20
`define QRSS_ZERO_RUN    14
`endif
